// *** hw/pcs_sequencer.sv ***
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`default_nettype none

module pcs_sequencer (
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Decoded instruction from the core
    input  wire logic        exec_valid,
    input  wire logic [4:0]  exec_op,
    input  wire logic [7:0]  exec_addr,
    input  wire logic [7:0]  exec_imm,
    input  wire logic [7:0]  exec_mem,
    input  wire logic [7:0]  exec_acc,
    input  wire logic        exec_carry,
    input  wire logic        exec_bit,
    input  wire logic [9:0]  exec_target,
    output logic             exec_busy,
    // Fetch address and accumulator write-back
    output logic      [9:0]  fetch_addr,
    output logic             acc_wr,
    output logic      [7:0]  acc_wdata,
    // Data RAM
    output logic             ram_re,
    output logic             ram_we,
    output logic      [7:0]  ram_bank,
    output logic      [7:0]  ram_loc,
    output logic      [7:0]  ram_wdata,
    input  wire logic [7:0]  ram_rdata,
    // Program memory lookup
    output logic             rom_req,
    output logic      [15:0] rom_addr,
    input  wire logic [15:0] rom_rdata
);

    //======================================================================
    // State
    //======================================================================
    typedef struct packed {
        logic [9:0]        fc;
        logic [7:0]        ptr_lo;
        logic [7:0]        ptr_hi;
        logic [7:0]        lookup_hi;
        logic              imm_err;
        logic              skipped;
        logic [31:0]       prdata;
        logic              pready;
        logic              pslverr;
        pcs_pkg::pcs_pend_t pend;
        logic              busy;
        logic              acc_wr;
        logic [7:0]        acc_wdata;
        logic              ram_re;
        logic              ram_we;
        logic [7:0]        ram_bank;
        logic [7:0]        ram_loc;
        logic [7:0]        ram_wdata;
        logic              rom_req;
        logic [15:0]       rom_addr;
    } pcs_state_t;

    pcs_state_t st_r;
    pcs_state_t st_nxt;

    //======================================================================
    // Decode helpers
    //======================================================================
    // True for a data address that lives in this block
    function automatic logic is_own(input logic [7:0] a);
        is_own = (a == pcs_pkg::DA_LOOKUP_HI) || (a == pcs_pkg::DA_PTR_LO)
              || (a == pcs_pkg::DA_PTR_HI)    || (a == pcs_pkg::DA_FC_LOWER)
              || (a == pcs_pkg::DA_FC_UPPER);
    endfunction : is_own

    // Read value of an own register; upper counter bits pad with zero
    function automatic logic [7:0] own_read(input pcs_state_t s,
                                            input logic [7:0] a);
        case (a)
            pcs_pkg::DA_LOOKUP_HI: own_read = s.lookup_hi;
            pcs_pkg::DA_PTR_LO:    own_read = s.ptr_lo;
            pcs_pkg::DA_PTR_HI:    own_read = s.ptr_hi;
            pcs_pkg::DA_FC_LOWER:  own_read = s.fc[7:0];
            pcs_pkg::DA_FC_UPPER:  own_read = {6'h00, s.fc[9:8]};
            default:               own_read = pcs_pkg::BYTE_ZERO;
        endcase
    endfunction : own_read

    //======================================================================
    // Next-state logic
    //======================================================================
    pcs_pkg::pcs_op_t op;
    logic             take;
    logic             skip;
    logic             dw_en;
    logic [7:0]       dw_addr;
    logic [7:0]       dw_data;
    logic             dw_carry;
    logic             rd_en;
    logic [7:0]       operand;
    logic [8:0]       sum;
    logic [7:0]       res;
    logic             apb_wr;
    logic [9:0]       apb_ix;

    always_comb begin
        st_nxt   = st_r;
        op       = pcs_pkg::pcs_op_t'(exec_op);
        skip     = 1'b0;
        dw_en    = 1'b0;
        dw_addr  = exec_addr;
        dw_data  = pcs_pkg::BYTE_ZERO;
        dw_carry = 1'b0;
        rd_en    = 1'b0;
        sum      = 9'h000;
        res      = pcs_pkg::BYTE_ZERO;
        apb_wr   = 1'b0;
        apb_ix   = paddr[11:2];

        // Pulses last one cycle unless renewed below
        st_nxt.acc_wr  = 1'b0;
        st_nxt.ram_re  = 1'b0;
        st_nxt.ram_we  = 1'b0;
        st_nxt.rom_req = 1'b0;
        st_nxt.pend    = pcs_pkg::PEND_NONE;

        // Memory operand: own registers are sourced here, not from the core
        operand = is_own(exec_addr) ? own_read(st_r, exec_addr) : exec_mem;

        // Instructions are ignored while a memory answer is outstanding
        take = exec_valid && (st_r.pend == pcs_pkg::PEND_NONE);

        //------------------------------------------------------------------
        // Instruction execution
        //------------------------------------------------------------------
        if (take) begin
            case (op)
                pcs_pkg::OP_CMP_IMM_SKIP: begin
                    skip = (exec_acc == exec_imm);
                end
                pcs_pkg::OP_CMP_MEM_SKIP: begin
                    skip = (exec_acc == operand);
                end
                pcs_pkg::OP_INC_SKIP, pcs_pkg::OP_INCM_SKIP: begin
                    res  = operand + pcs_pkg::BYTE_ONE;
                    skip = (operand == pcs_pkg::BYTE_FF);
                    if (op == pcs_pkg::OP_INCM_SKIP) begin
                        dw_en   = 1'b1;
                        dw_data = res;
                    end else begin
                        st_nxt.acc_wr    = 1'b1;
                        st_nxt.acc_wdata = res;
                    end
                end
                pcs_pkg::OP_DEC_SKIP, pcs_pkg::OP_DECM_SKIP: begin
                    res  = operand - pcs_pkg::BYTE_ONE;
                    skip = (operand == pcs_pkg::BYTE_ONE);
                    if (op == pcs_pkg::OP_DECM_SKIP) begin
                        dw_en   = 1'b1;
                        dw_data = res;
                    end else begin
                        st_nxt.acc_wr    = 1'b1;
                        st_nxt.acc_wdata = res;
                    end
                end
                pcs_pkg::OP_BIT_CLR_SKIP, pcs_pkg::OP_B0_BIT_CLR_SKIP: begin
                    skip = !exec_bit;
                end
                pcs_pkg::OP_BIT_SET_SKIP, pcs_pkg::OP_B0_BIT_SET_SKIP: begin
                    skip = exec_bit;
                end
                pcs_pkg::OP_ADD_MEM, pcs_pkg::OP_ADC_MEM,
                pcs_pkg::OP_BANK0_ADD_OP_MEM: begin
                    sum = {1'b0, operand} + {1'b0, exec_acc}
                        + {8'h00, (op == pcs_pkg::OP_ADC_MEM) && exec_carry};
                    dw_en    = 1'b1;
                    dw_data  = sum[7:0];
                    dw_carry = sum[8];
                end
                pcs_pkg::OP_SUB_MEM: begin
                    // Borrow is dropped: upper byte never counts down
                    dw_en   = 1'b1;
                    dw_data = operand - exec_acc;
                end
                pcs_pkg::OP_MOV_TO_MEM: begin
                    dw_en   = 1'b1;
                    dw_data = exec_acc;
                end
                pcs_pkg::OP_MOV_IMM: begin
                    // Outside the window the write is dropped and flagged
                    if (exec_addr >= pcs_pkg::DA_IMM_FIRST &&
                        exec_addr <= pcs_pkg::DA_IMM_LAST) begin
                        dw_en   = 1'b1;
                        dw_data = exec_imm;
                    end else begin
                        st_nxt.imm_err = 1'b1;
                    end
                end
                pcs_pkg::OP_MOV_FROM_MEM: begin
                    rd_en = 1'b1;
                end
                pcs_pkg::OP_ROM_LOOKUP: begin
                    st_nxt.rom_req  = 1'b1;
                    st_nxt.rom_addr = {st_r.ptr_hi, st_r.ptr_lo};
                    st_nxt.pend     = pcs_pkg::PEND_ROM;
                end
                default: begin
                end
            endcase

            // Fetch counter: load, write, skip or plain step
            if (op == pcs_pkg::OP_JUMP || op == pcs_pkg::OP_CALL ||
                op == pcs_pkg::OP_RET) begin
                st_nxt.fc = exec_target;
            end else if (dw_en && dw_addr == pcs_pkg::DA_FC_LOWER) begin
                // Page-relative jump; upper byte only follows a carry
                st_nxt.fc = {st_r.fc[9:8] + {1'b0, dw_carry},
                             dw_data};
            end else if (dw_en && dw_addr == pcs_pkg::DA_FC_UPPER) begin
                st_nxt.fc = {dw_data[1:0], st_r.fc[7:0]};
            end else if (skip) begin
                // Skipped word is never fetched, so it cannot act
                st_nxt.fc = st_r.fc + pcs_pkg::FC_SKIP_STEP;
            end else begin
                st_nxt.fc = st_r.fc + pcs_pkg::FC_STEP;
            end
            st_nxt.skipped = skip;

            // Data writes: own registers, indirect window or plain RAM
            if (dw_en) begin
                case (dw_addr)
                    pcs_pkg::DA_LOOKUP_HI: st_nxt.lookup_hi = dw_data;
                    pcs_pkg::DA_PTR_LO:    st_nxt.ptr_lo    = dw_data;
                    pcs_pkg::DA_PTR_HI:    st_nxt.ptr_hi    = dw_data;
                    pcs_pkg::DA_FC_LOWER, pcs_pkg::DA_FC_UPPER: begin
                    end
                    pcs_pkg::DA_INDIRECT: begin
                        st_nxt.ram_we    = 1'b1;
                        st_nxt.ram_bank  = st_r.ptr_hi;
                        st_nxt.ram_loc   = st_r.ptr_lo;
                        st_nxt.ram_wdata = dw_data;
                    end
                    default: begin
                        st_nxt.ram_we    = 1'b1;
                        st_nxt.ram_bank  = pcs_pkg::BANK_DIRECT;
                        st_nxt.ram_loc   = dw_addr;
                        st_nxt.ram_wdata = dw_data;
                    end
                endcase
            end

            // Data reads into the accumulator
            if (rd_en) begin
                if (is_own(exec_addr)) begin
                    st_nxt.acc_wr    = 1'b1;
                    st_nxt.acc_wdata = operand;
                end else begin
                    st_nxt.ram_re = 1'b1;
                    st_nxt.pend   = pcs_pkg::PEND_RAM;
                    if (exec_addr == pcs_pkg::DA_INDIRECT) begin
                        st_nxt.ram_bank = st_r.ptr_hi;
                        st_nxt.ram_loc  = st_r.ptr_lo;
                    end else begin
                        st_nxt.ram_bank = pcs_pkg::BANK_DIRECT;
                        st_nxt.ram_loc  = exec_addr;
                    end
                end
            end
        end

        //------------------------------------------------------------------
        // Memory answers, one cycle after the request
        st_nxt.busy = (st_nxt.pend != pcs_pkg::PEND_NONE);
        //------------------------------------------------------------------
        if (st_r.pend == pcs_pkg::PEND_RAM) begin
            st_nxt.acc_wr    = 1'b1;
            st_nxt.acc_wdata = ram_rdata;
        end else if (st_r.pend == pcs_pkg::PEND_ROM) begin
            st_nxt.lookup_hi = rom_rdata[15:8];
            st_nxt.acc_wr    = 1'b1;
            st_nxt.acc_wdata = rom_rdata[7:0];
        end

        //------------------------------------------------------------------
        // APB slave: answer prepared in setup, given in the first access
        //------------------------------------------------------------------
        st_nxt.pready  = psel && !penable;
        st_nxt.pslverr = 1'b0;
        if (psel && !penable) begin
            st_nxt.pslverr = !(is_own(apb_ix[7:0]) && apb_ix[9:8] == 2'b00)
                          && (apb_ix != pcs_pkg::IX_STATUS);
            st_nxt.prdata  = 32'h0000_0000;
            if (apb_ix == pcs_pkg::IX_STATUS) begin
                st_nxt.prdata[pcs_pkg::ST_IMM_ERR] = st_r.imm_err;
                st_nxt.prdata[pcs_pkg::ST_SKIPPED] = st_r.skipped;
            end else if (apb_ix[9:8] == 2'b00) begin
                st_nxt.prdata[7:0] = own_read(st_r, apb_ix[7:0]);
            end
        end
        apb_wr = psel && penable && st_r.pready && pwrite && !st_r.pslverr;

        // Software writes win over the core in the same cycle, except a status clear, which loses to a new error
        if (apb_wr) begin
            case (apb_ix)
                pcs_pkg::IX_LOOKUP_HI: st_nxt.lookup_hi = pwdata[7:0];
                pcs_pkg::IX_PTR_LO:    st_nxt.ptr_lo    = pwdata[7:0];
                pcs_pkg::IX_PTR_HI:    st_nxt.ptr_hi    = pwdata[7:0];
                pcs_pkg::IX_FC_LOWER:  st_nxt.fc[7:0]   = pwdata[7:0];
                pcs_pkg::IX_FC_UPPER:  st_nxt.fc[9:8]   = pwdata[1:0];
                pcs_pkg::IX_STATUS: begin
                    // Write one to clear; a new error in this cycle wins
                    if (pwdata[pcs_pkg::ST_IMM_ERR] && !(take &&
                        op == pcs_pkg::OP_MOV_IMM && !dw_en)) begin
                        st_nxt.imm_err = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    //======================================================================
    // State register
    //======================================================================
    // Pointers also clear here only so that reset state is deterministic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r           <= '0;
            st_r.fc        <= pcs_pkg::FC_RESET;
            st_r.ptr_lo    <= pcs_pkg::REG_RESET;
            st_r.ptr_hi    <= pcs_pkg::REG_RESET;
            st_r.lookup_hi <= pcs_pkg::REG_RESET;
            st_r.pend      <= pcs_pkg::PEND_NONE;
        end else begin
            st_r <= st_nxt;
        end
    end

    //======================================================================
    // Outputs, all straight from the state register
    //======================================================================
    assign prdata     = st_r.prdata;
    assign pready     = st_r.pready;
    assign pslverr    = st_r.pslverr;
    assign fetch_addr = st_r.fc;
    assign exec_busy  = st_r.busy;
    assign acc_wr     = st_r.acc_wr;
    assign acc_wdata  = st_r.acc_wdata;
    assign ram_re     = st_r.ram_re;
    assign ram_we     = st_r.ram_we;
    assign ram_bank   = st_r.ram_bank;
    assign ram_loc    = st_r.ram_loc;
    assign ram_wdata  = st_r.ram_wdata;
    assign rom_req    = st_r.rom_req;
    assign rom_addr   = st_r.rom_addr;

endmodule : pcs_sequencer

`default_nettype wire

// *** hw/pcs_pkg.sv ***
//==========================================================================
// Constants and types shared by the sequencer and its surroundings
//==========================================================================
package pcs_pkg;

    // Data-space addresses of the block's own registers and the indirect window
    localparam logic [7:0] DA_LOOKUP_HI  = 8'h82;
    localparam logic [7:0] DA_PTR_LO     = 8'h83;
    localparam logic [7:0] DA_PTR_HI     = 8'h84;
    localparam logic [7:0] DA_FC_LOWER   = 8'hCE;
    localparam logic [7:0] DA_FC_UPPER   = 8'hCF;
    localparam logic [7:0] DA_INDIRECT   = 8'hE7;
    // Window of working registers that accept immediate writes
    localparam logic [7:0] DA_IMM_FIRST  = 8'h80;
    localparam logic [7:0] DA_IMM_LAST   = 8'h87;
    // Bank used by direct addressing
    localparam logic [7:0] BANK_DIRECT   = 8'h00;

    // APB word indices; byte address is four times the index
    localparam logic [9:0] IX_LOOKUP_HI  = 10'h082;
    localparam logic [9:0] IX_PTR_LO     = 10'h083;
    localparam logic [9:0] IX_PTR_HI     = 10'h084;
    localparam logic [9:0] IX_FC_LOWER   = 10'h0CE;
    localparam logic [9:0] IX_FC_UPPER   = 10'h0CF;
    localparam logic [9:0] IX_STATUS     = 10'h040;

    // Status register fields
    localparam int         ST_IMM_ERR    = 0;
    localparam int         ST_SKIPPED    = 1;

    // Reset values and arithmetic constants
    localparam logic [9:0] FC_RESET      = 10'h000;
    localparam logic [7:0] REG_RESET     = 8'h00;
    localparam logic [9:0] FC_STEP       = 10'h001;
    localparam logic [9:0] FC_SKIP_STEP  = 10'h002;
    localparam logic [7:0] BYTE_ONE      = 8'h01;
    localparam logic [7:0] BYTE_FF       = 8'hFF;
    localparam logic [7:0] BYTE_ZERO     = 8'h00;

    // Instruction classes presented by the decoder
    typedef enum logic [4:0] {
        OP_NEXT, OP_JUMP, OP_CALL, OP_RET,
        OP_CMP_IMM_SKIP, OP_CMP_MEM_SKIP,
        OP_INC_SKIP, OP_INCM_SKIP, OP_DEC_SKIP, OP_DECM_SKIP,
        OP_BIT_CLR_SKIP, OP_BIT_SET_SKIP,
        OP_B0_BIT_CLR_SKIP, OP_B0_BIT_SET_SKIP,
        OP_ADD_MEM, OP_ADC_MEM, OP_BANK0_ADD_OP_MEM, OP_SUB_MEM,
        OP_MOV_TO_MEM, OP_MOV_IMM, OP_MOV_FROM_MEM, OP_ROM_LOOKUP
    } pcs_op_t;

    // Kind of answer outstanding from memory
    typedef enum logic [1:0] {
        PEND_NONE, PEND_RAM, PEND_ROM
    } pcs_pend_t;

endpackage : pcs_pkg

// *** bench/pcs_sequencer_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
//======================================================================
// Port checks for the fetch sequencer
//======================================================================
module pcs_sequencer_sva (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       exec_valid,
    input wire logic [4:0] exec_op,
    input wire logic [7:0] exec_addr,
    input wire logic [7:0] exec_imm,
    input wire logic [7:0] exec_mem,
    input wire logic [7:0] exec_acc,
    input wire logic       exec_bit,
    input wire logic [9:0] exec_target,
    input wire logic       exec_busy,
    input wire logic [9:0] fetch_addr,
    input wire logic       acc_wr,
    input wire logic       rom_req
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Taken instruction; a bus access may override the counter, so skip those
    logic go;
    assign go = exec_valid && !exec_busy && !(psel && penable);

    a_reset_clear: assert property ($rose(presetn) |-> fetch_addr == 10'h000)
        else $error("fetch counter not clear after reset");
    a_step_one: assert property (go && exec_op == pcs_pkg::OP_NEXT
        |=> fetch_addr == $past(fetch_addr) + 10'h001) else $error("no step");
    a_jump_load: assert property (go && exec_op inside {pcs_pkg::OP_JUMP,
        pcs_pkg::OP_CALL} |=> fetch_addr == $past(exec_target)) else $error("bad jump");
    a_cmp_skip: assert property (go && exec_op == pcs_pkg::OP_CMP_IMM_SKIP
        && exec_acc == exec_imm |=> fetch_addr == $past(fetch_addr) + 10'h002)
        else $error("compare did not skip");
    a_inc_wrap: assert property (go && exec_op == pcs_pkg::OP_INC_SKIP
        && exec_mem == 8'hFF && exec_addr < 8'h80
        |=> fetch_addr == $past(fetch_addr) + 10'h002)
        else $error("wrap did not skip");
    a_dec_zero: assert property (go && exec_op == pcs_pkg::OP_DECM_SKIP
        && exec_mem == 8'h01 && exec_addr < 8'h80
        |=> fetch_addr == $past(fetch_addr) + 10'h002)
        else $error("decrement did not skip");
    a_bit_match: assert property (go && exec_bit && exec_op inside
        {pcs_pkg::OP_BIT_SET_SKIP, pcs_pkg::OP_B0_BIT_SET_SKIP}
        |=> fetch_addr == $past(fetch_addr) + 10'h002) else $error("bit skip");
    a_lookup_seq: assert property (go && exec_op == pcs_pkg::OP_ROM_LOOKUP
        |=> rom_req ##[1:2] acc_wr) else $error("lookup not answered");
    a_pready_once: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready not a single pulse");

    // Main scenarios reached
    c_lookup: cover property (go && exec_op == pcs_pkg::OP_ROM_LOOKUP);
    c_add: cover property (go && exec_op == pcs_pkg::OP_ADD_MEM);
    c_apb: cover property (psel && penable && pready);
endmodule : pcs_sequencer_sva

bind pcs_sequencer pcs_sequencer_sva pcs_sequencer_sva_inst (.pclk, .presetn,
    .psel, .penable, .pready, .exec_valid, .exec_op, .exec_addr, .exec_imm,
    .exec_mem, .exec_acc, .exec_bit, .exec_target, .exec_busy, .fetch_addr,
    .acc_wr, .rom_req);
`default_nettype wire

// *** bench/pcs_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
//======================================================================
// Data RAM and program memory beside the sequencer
//======================================================================
module pcs_mem_model (
    input wire logic        pclk,
    input wire logic        ram_re,
    input wire logic        ram_we,
    input wire logic [7:0]  ram_loc,
    input wire logic [7:0]  ram_wdata,
    output logic     [7:0]  ram_rdata,
    input wire logic        rom_req,
    input wire logic [15:0] rom_addr,
    output logic     [15:0] rom_rdata
);
    // Bank ignored: one page stands in for all banks, enough for these tests
    logic [7:0] mem [256];
    // Answers stand with the request; the design takes them at its end edge
    always @(posedge pclk) if (ram_we) mem[ram_loc] <= ram_wdata;
    // Idle lines show the inverse, so a sample taken too late cannot pass
    assign ram_rdata = mem[ram_loc] ^ {8{!ram_re}};
    assign rom_rdata = {16{!rom_req}}
                     ^ {~rom_addr[7:0], rom_addr[15:8] ^ rom_addr[7:0]};
endmodule : pcs_mem_model
`default_nettype wire

// *** bench/tb_pcs_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none
//======================================================================
// Bench for the fetch sequencer
//======================================================================
module tb_pcs_sequencer;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, exec_valid = 1'b0, exec_carry = 1'b0;
    logic        exec_bit = 1'b0, pready, pslverr, exec_busy, acc_wr, er;
    logic        ram_re, ram_we, rom_req;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [4:0]  exec_op = 5'h00;
    logic [7:0]  exec_addr = 8'h00, exec_imm = 8'h00, exec_mem = 8'h00;
    logic [7:0]  exec_acc = 8'h00, acc_wdata, ram_bank, ram_loc, ram_wdata;
    logic [7:0]  ram_rdata;
    logic [9:0]  exec_target = 10'h000, fetch_addr, pc = 10'h000;
    logic [15:0] rom_addr, rom_rdata;
    int          err_count = 0, total_checks = 0;
    always #12.5 pclk = ~pclk;

    pcs_sequencer pcs_sequencer_inst (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .exec_valid,
        .exec_op, .exec_addr, .exec_imm, .exec_mem, .exec_acc, .exec_carry,
        .exec_bit, .exec_target, .exec_busy, .fetch_addr, .acc_wr, .acc_wdata,
        .ram_re, .ram_we, .ram_bank, .ram_loc, .ram_wdata, .ram_rdata,
        .rom_req, .rom_addr, .rom_rdata);
    pcs_mem_model pcs_mem_model_inst (.pclk, .ram_re, .ram_we, .ram_loc,
        .ram_wdata, .ram_rdata, .rom_req, .rom_addr, .rom_rdata);

    //==================================================================
    // Shared helpers
    //==================================================================
    task automatic chk(input logic [31:0] s, x);
        total_checks++;
        if (s !== x) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, x);
        end
    endtask : chk
    // APB master: hold the request until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    // One instruction, then the counter is compared with the next address n
    task automatic ex(input logic [4:0] o, input logic [7:0] a, m, c,
                      input logic b, input logic [9:0] t, n);
        @(posedge pclk);
        {exec_op, exec_addr, exec_mem, exec_imm, exec_acc, exec_bit,
         exec_target, exec_valid} <= {o, a, m, m, c, b, t, 1'b1};
        @(posedge pclk);
        exec_valid <= 1'b0;
        @(negedge pclk);
        pc = n;
        chk(fetch_addr, n);
    endtask : ex
    // Memory answers land later than the instruction, so wait a bounded span
    task automatic acc_wait(input logic [7:0] x);
        for (int n = 0; n < 8 && acc_wr !== 1'b1; n++) @(negedge pclk);
        chk({acc_wr, acc_wdata}, {1'b1, x});
    endtask : acc_wait

    //==================================================================
    // Scenarios
    //==================================================================
    task automatic t_reset;
        apb(1'b0, 12'h33C, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 12'hFFC, 32'h5);
        chk({31'h0, er}, 32'h1);
    endtask : t_reset
    task automatic t_flow;
        ex(pcs_pkg::OP_NEXT, 8'h10, 8'h00, 8'h00, 1'b0, 10'h155, 10'h001);
        ex(pcs_pkg::OP_JUMP, 8'h10, 8'h00, 8'h00, 1'b0, 10'h3FF, 10'h3FF);
        ex(pcs_pkg::OP_CALL, 8'h10, 8'h00, 8'h00, 1'b0, 10'h323, 10'h323);
    endtask : t_flow
    // Operand, accumulator, tested bit and step per skip-capable form
    logic [4:0] sk_op [10] = '{pcs_pkg::OP_CMP_IMM_SKIP, pcs_pkg::OP_CMP_MEM_SKIP,
        pcs_pkg::OP_INC_SKIP, pcs_pkg::OP_INCM_SKIP, pcs_pkg::OP_DEC_SKIP,
        pcs_pkg::OP_DECM_SKIP, pcs_pkg::OP_BIT_CLR_SKIP, pcs_pkg::OP_BIT_SET_SKIP,
        pcs_pkg::OP_B0_BIT_CLR_SKIP, pcs_pkg::OP_B0_BIT_SET_SKIP};
    logic [23:0] sk_arg [10] = '{24'h121202, 24'h131201, 24'hFF0002,
        24'hFE0001, 24'h010002, 24'h010002, 24'h000002, 24'h000012,
        24'h000011, 24'h000012};
    task automatic t_skips;
        for (int i = 0; i < 10; i++) begin
            ex(sk_op[i], 8'h10, sk_arg[i][23:16], sk_arg[i][15:8],
               sk_arg[i][4], pc, pc + sk_arg[i][1:0]);
        end
    endtask : t_skips
    task automatic t_lower;
        ex(pcs_pkg::OP_JUMP, 8'h10, 8'h00, 8'h00, 1'b0, 10'h0F0, 10'h0F0);
        ex(pcs_pkg::OP_ADD_MEM, 8'hCE, 8'h00, 8'h20, 1'b0, pc, 10'h110);
        ex(pcs_pkg::OP_SUB_MEM, 8'hCE, 8'h00, 8'h20, 1'b0, pc, 10'h1F0);
        ex(pcs_pkg::OP_JUMP, 8'h10, 8'h00, 8'h00, 1'b0, 10'h323, 10'h323);
        ex(pcs_pkg::OP_MOV_TO_MEM, 8'hCE, 8'h00, 8'h28, 1'b0, pc, 10'h328);
    endtask : t_lower
    task automatic t_ptr;
        apb(1'b1, 12'h210, 32'h1);
        apb(1'b1, 12'h20C, 32'h25);
        apb(1'b0, 12'h210, 32'h0);
        chk(rd, 32'h1);
        ex(pcs_pkg::OP_MOV_TO_MEM, 8'hE7, 8'h00, 8'h5A, 1'b0, pc, pc + 10'h001);
        chk({ram_we, ram_bank, ram_loc, ram_wdata}, 25'h101255A);
        ex(pcs_pkg::OP_ROM_LOOKUP, 8'h10, 8'h00, 8'h00, 1'b0, pc, pc + 10'h001);
        chk({rom_req, rom_addr}, 17'h10125);
        acc_wait(8'h24);
        apb(1'b0, 12'h208, 32'h0);
        chk(rd, 32'hDA);
    endtask : t_ptr
    task automatic t_direct;
        ex(pcs_pkg::OP_MOV_TO_MEM, 8'h12, 8'h00, 8'h34, 1'b0, pc, pc + 10'h001);
        chk({ram_we, ram_bank, ram_loc}, 17'h10012);
        ex(pcs_pkg::OP_MOV_FROM_MEM, 8'h12, 8'h00, 8'h00, 1'b0, pc, pc + 10'h001);
        chk({ram_re, exec_busy, ram_loc}, 10'h312);
        acc_wait(8'h34);
        ex(pcs_pkg::OP_MOV_IMM, 8'h82, 8'h12, 8'h00, 1'b0, pc, pc + 10'h001);
        apb(1'b0, 12'h208, 32'h0);
        chk(rd, 32'h12);
        ex(pcs_pkg::OP_MOV_IMM, 8'h90, 8'h77, 8'h00, 1'b0, pc, pc + 10'h001);
        apb(1'b0, 12'h100, 32'h0);
        chk({31'h0, rd[0]}, 32'h1);
    endtask : t_direct

    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : close_out
    // Whole run is about a hundred cycles; this cuts a hang short
    initial begin
        #100000;
        err_count++;
        close_out();
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_flow();
        t_skips();
        t_lower();
        t_ptr();
        t_direct();
        close_out();
    end
endmodule : tb_pcs_sequencer
`default_nettype wire
